// File: hw/triple_timer.sv
// Three timer/counter channels with clock output, reached over a plain register port.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module triple_timer #(
	parameter int ADDR_WIDTH = timer_pkg::ADDR_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Register port.
	input wire logic [ADDR_WIDTH-1:0] addr,
	input wire logic [timer_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [timer_pkg::DATA_W-1:0] rdata,
	// External pins.
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic t0_count_pin,
	input wire logic t1_count_pin,
	input wire logic timer2_trigger_pin,
	input wire logic p1_0_in,
	output logic p1_0_out,
	output logic p1_0_oe,
	// Ticks to the serial port.
	output logic timer1_ovf_tick,
	output logic rx_baud_tick,
	output logic tx_baud_tick
);
	import timer_pkg::*;

	initial
	begin
		if (ADDR_WIDTH < ADDR_W)
			$error("register port address too narrow for the map");
	end

	logic [7:0] timer01_mode_byte_reg;
	logic [7:0] ctrl01_reg;
	logic [7:0] timer0_low_byte_reg, timer0_high_byte_reg;
	logic [7:0] timer1_low_byte_reg, timer1_high_byte_reg;
	logic [7:0] timer2_control_reg, timer2_mode_reg;
	logic [7:0] timer2_reload_low_reg, timer2_reload_high_reg;
	logic [7:0] timer2_low_byte_reg, timer2_high_byte_reg;
	logic clk_double_reg;
	logic [3:0] presc_reg;
	logic half_reg;
	logic clkout_reg;
	logic [3:0] falls;
	logic [3:0] addr_lo;

	assign addr_lo = addr[ADDR_W-1:0];

	// Steps a 13-bit, 16-bit, 8-bit reload or split low counter; bit 16 is the overflow.
	function automatic logic [16:0] step01(input logic [1:0] mode, input logic [7:0] hi, input logic [7:0] lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		unique case (mode)
			MODE_13BIT:
			begin
				if (lo[4:0] == PRESCALE_FULL)
					r = {hi == BYTE_FULL, hi + 8'h01, lo[7:5], 5'h00};
				else
					r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
			end
			MODE_16BIT:
				r = {1'b0, hi, lo} + 17'h00001;
			MODE_RELOAD8:
			begin
				if (lo == BYTE_FULL)
					r = {1'b1, hi, hi};
				else
					r = {1'b0, hi, lo + 8'h01};
			end
			MODE_SPLIT:
				r = {lo == BYTE_FULL, hi, lo + 8'h01};
		endcase
		return r;
	endfunction

	fall_detect #(
		.WIDTH(4)
	) u_fall (
		.clk(clk),
		.rstn(rstn),
		.pin({timer2_trigger_pin, p1_0_in, t1_count_pin, t0_count_pin}),
		.fall(falls)
	);

	// Field decode.
	logic [1:0] mode0, mode1;
	logic count_sel0, count_sel1, gate0, gate1;
	logic timer0_run, timer1_run, timer2_run;
	logic timer2_counter_select, timer2_clockout_enable, cap_mode, ext_en, baud_mode;
	assign mode0 = timer01_mode_byte_reg[MODE_LSB+:2];
	assign count_sel0 = timer01_mode_byte_reg[COUNT_SEL_BIT];
	assign gate0 = timer01_mode_byte_reg[GATE_BIT];
	assign mode1 = timer01_mode_byte_reg[NIBBLE_1+MODE_LSB+:2];
	assign count_sel1 = timer01_mode_byte_reg[NIBBLE_1+COUNT_SEL_BIT];
	assign gate1 = timer01_mode_byte_reg[NIBBLE_1+GATE_BIT];
	assign timer0_run = ctrl01_reg[C01_RUN0];
	assign timer1_run = ctrl01_reg[C01_RUN1];
	assign timer2_run = timer2_control_reg[C2_RUN];
	assign timer2_counter_select = timer2_control_reg[C2_COUNT_SEL];
	assign cap_mode = timer2_control_reg[C2_CAP_RLD];
	assign ext_en = timer2_control_reg[C2_EXT_EN];
	assign baud_mode = timer2_control_reg[C2_RX_BAUD] | timer2_control_reg[C2_TX_BAUD];
	assign timer2_clockout_enable = timer2_mode_reg[M2_CLKOUT_EN];

	// Machine-cycle prescaler and the tick used by baud and clock-out counting: half rate, or every clock with clock doubling.
	logic mc_tick, fast_tick;
	logic [3:0] mc_len;
	assign mc_len = clk_double_reg ? MC_CLOCKS_DBL : MC_CLOCKS_STD;
	assign mc_tick = (presc_reg == mc_len - 4'h1);
	assign fast_tick = clk_double_reg | half_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			presc_reg <= 4'h0;
			half_reg <= 1'b0;
		end
		else
		begin
			presc_reg <= (mc_tick || presc_reg >= mc_len) ? 4'h0 : presc_reg + 4'h1;
			half_reg <= ~half_reg;
		end
	end

	// Increment enables for channels 0 and 1.
	logic run_ok0, run_ok1, inc0, inc0_high, inc1;
	logic [16:0] step0, step1;
	assign run_ok0 = timer0_run & (~gate0 | ext_irq0_pin);
	assign run_ok1 = timer1_run & (~gate1 | ext_irq1_pin) & (mode1 != MODE_SPLIT);
	assign inc0 = run_ok0 & (count_sel0 ? falls[0] : mc_tick);
	assign inc1 = run_ok1 & (count_sel1 ? falls[1] : mc_tick);
	assign inc0_high = (mode0 == MODE_SPLIT) & timer1_run & mc_tick;
	assign step0 = step01(mode0, timer0_high_byte_reg, timer0_low_byte_reg);
	assign step1 = step01(mode1, timer1_high_byte_reg, timer1_low_byte_reg);

	logic ovf0, ovf0_high, ovf1;
	assign ovf0 = inc0 & step0[16];
	assign ovf0_high = inc0_high & (timer0_high_byte_reg == BYTE_FULL);
	assign ovf1 = inc1 & step1[16];

	// Register writes take priority over counting on the same byte.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timer0_low_byte_reg <= RESET_BYTE;
			timer0_high_byte_reg <= RESET_BYTE;
		end
		else
		begin
			if (wr && addr_lo == ADDR_T0_LOW)
				timer0_low_byte_reg <= wdata;
			else if (inc0)
				timer0_low_byte_reg <= step0[7:0];
			if (wr && addr_lo == ADDR_T0_HIGH)
				timer0_high_byte_reg <= wdata;
			else if (inc0_high)
				timer0_high_byte_reg <= timer0_high_byte_reg + 8'h01;
			else if (inc0 && mode0 != MODE_SPLIT)
				timer0_high_byte_reg <= step0[15:8];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timer1_low_byte_reg <= RESET_BYTE;
			timer1_high_byte_reg <= RESET_BYTE;
		end
		else
		begin
			if (wr && addr_lo == ADDR_T1_LOW)
				timer1_low_byte_reg <= wdata;
			else if (inc1)
				timer1_low_byte_reg <= step1[7:0];
			if (wr && addr_lo == ADDR_T1_HIGH)
				timer1_high_byte_reg <= wdata;
			else if (inc1)
				timer1_high_byte_reg <= step1[15:8];
		end
	end

	// Mode, control and configuration registers; overflow flags are set-wins over a software clear.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timer01_mode_byte_reg <= RESET_BYTE;
			ctrl01_reg <= RESET_BYTE;
			timer2_mode_reg <= RESET_BYTE;
			clk_double_reg <= 1'b0;
		end
		else
		begin
			if (wr && addr_lo == ADDR_MODE01)
				timer01_mode_byte_reg <= wdata;
			if (wr && addr_lo == ADDR_T2_MODE)
				timer2_mode_reg <= wdata;
			if (wr && addr_lo == ADDR_CORE_CFG)
				clk_double_reg <= wdata[CFG_CLK_DOUBLE];
			if (wr && addr_lo == ADDR_CTRL01)
				ctrl01_reg <= {4'h0, wdata[3:0]};
			// While channel 0 is split, its high half owns the channel 1 flag.
			if (ovf0)
				ctrl01_reg[C01_OVF0] <= 1'b1;
			if (ovf0_high || (ovf1 && mode0 != MODE_SPLIT))
				ctrl01_reg[C01_OVF1] <= 1'b1;
		end
	end

	// Channel 2.
	logic inc2, ovf2, trig2, ext_event;
	logic [15:0] count2, reload2;
	assign count2 = {timer2_high_byte_reg, timer2_low_byte_reg};
	assign reload2 = {timer2_reload_high_reg, timer2_reload_low_reg};
	assign inc2 = timer2_run & (timer2_counter_select ? falls[2] :
		((baud_mode | timer2_clockout_enable) ? fast_tick : mc_tick));
	assign ovf2 = inc2 & (count2 == WORD_FULL);
	assign ext_event = ext_en & falls[3];
	assign trig2 = ext_event & ~baud_mode;

	logic reload_on_ovf;
	logic [15:0] count2_next;
	assign reload_on_ovf = baud_mode | timer2_clockout_enable | ~cap_mode;

	always_comb
	begin
		count2_next = count2;
		if (ovf2)
			count2_next = reload_on_ovf ? reload2 : 16'h0000;
		else if (inc2)
			count2_next = count2 + 16'h0001;
		if (trig2 && !cap_mode)
			count2_next = reload2;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timer2_low_byte_reg <= RESET_BYTE;
			timer2_high_byte_reg <= RESET_BYTE;
		end
		else
		begin
			timer2_low_byte_reg <= (wr && addr_lo == ADDR_T2_LOW) ? wdata : count2_next[7:0];
			timer2_high_byte_reg <= (wr && addr_lo == ADDR_T2_HIGH) ? wdata : count2_next[15:8];
		end
	end

	// Capture registers double as the reload word.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timer2_reload_low_reg <= RESET_BYTE;
			timer2_reload_high_reg <= RESET_BYTE;
		end
		else
		begin
			if (wr && addr_lo == ADDR_T2_RLD_LOW)
				timer2_reload_low_reg <= wdata;
			else if (trig2 && cap_mode)
				timer2_reload_low_reg <= timer2_low_byte_reg;
			if (wr && addr_lo == ADDR_T2_RLD_HIGH)
				timer2_reload_high_reg <= wdata;
			else if (trig2 && cap_mode)
				timer2_reload_high_reg <= timer2_high_byte_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			timer2_control_reg <= RESET_BYTE;
		else
		begin
			if (wr && addr_lo == ADDR_T2_CTRL)
				timer2_control_reg <= wdata;
			if (ovf2 && !baud_mode && !timer2_clockout_enable)
				timer2_control_reg[C2_OVF_FLAG] <= 1'b1;
			if (trig2)
				timer2_control_reg[C2_EXT_FLAG] <= 1'b1;
		end
	end

	// Clock output toggles on each roll-over, giving a 50% duty square wave.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			clkout_reg <= 1'b0;
		else if (!timer2_clockout_enable)
			clkout_reg <= 1'b0;
		else if (ovf2)
			clkout_reg <= ~clkout_reg;
	end

	assign p1_0_out = clkout_reg;
	assign p1_0_oe = timer2_clockout_enable & ~timer2_counter_select;
	assign timer1_ovf_tick = ovf1;
	assign rx_baud_tick = ovf2 & timer2_control_reg[C2_RX_BAUD];
	assign tx_baud_tick = ovf2 & timer2_control_reg[C2_TX_BAUD];

	// Read data appear in the cycle after the read strobe only.
	always_ff @(posedge clk)
	begin
		if (!rstn || !rd)
			rdata <= RESET_BYTE;
		else
		begin
			unique case (addr_lo)
				ADDR_MODE01: rdata <= timer01_mode_byte_reg;
				ADDR_CTRL01: rdata <= ctrl01_reg;
				ADDR_T0_LOW: rdata <= timer0_low_byte_reg;
				ADDR_T0_HIGH: rdata <= timer0_high_byte_reg;
				ADDR_T1_LOW: rdata <= timer1_low_byte_reg;
				ADDR_T1_HIGH: rdata <= timer1_high_byte_reg;
				ADDR_T2_CTRL: rdata <= timer2_control_reg;
				ADDR_T2_MODE: rdata <= timer2_mode_reg;
				ADDR_T2_RLD_LOW: rdata <= timer2_reload_low_reg;
				ADDR_T2_RLD_HIGH: rdata <= timer2_reload_high_reg;
				ADDR_T2_LOW: rdata <= timer2_low_byte_reg;
				ADDR_T2_HIGH: rdata <= timer2_high_byte_reg;
				ADDR_CORE_CFG: rdata <= {7'h00, clk_double_reg};
				default: rdata <= RESET_BYTE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: hw/timer_pkg.sv
// Register map, field positions, mode codes and timing constants of the timer block.
package timer_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_MODE01 = 4'h0;
	localparam logic [3:0] ADDR_CTRL01 = 4'h1;
	localparam logic [3:0] ADDR_T0_LOW = 4'h2;
	localparam logic [3:0] ADDR_T0_HIGH = 4'h3;
	localparam logic [3:0] ADDR_T1_LOW = 4'h4;
	localparam logic [3:0] ADDR_T1_HIGH = 4'h5;
	localparam logic [3:0] ADDR_T2_CTRL = 4'h6;
	localparam logic [3:0] ADDR_T2_MODE = 4'h7;
	localparam logic [3:0] ADDR_T2_RLD_LOW = 4'h8;
	localparam logic [3:0] ADDR_T2_RLD_HIGH = 4'h9;
	localparam logic [3:0] ADDR_T2_LOW = 4'hA;
	localparam logic [3:0] ADDR_T2_HIGH = 4'hB;
	localparam logic [3:0] ADDR_CORE_CFG = 4'hC;
	// Fields of the shared mode byte; channel 1 uses the same layout in the high nibble.
	localparam int MODE_LSB = 0;
	localparam int COUNT_SEL_BIT = 2;
	localparam int GATE_BIT = 3;
	localparam int NIBBLE_1 = 4;
	// Fields of the channel 0/1 control register.
	localparam int C01_RUN0 = 0;
	localparam int C01_RUN1 = 1;
	localparam int C01_OVF0 = 2;
	localparam int C01_OVF1 = 3;
	// Fields of the channel 2 control register.
	localparam int C2_CAP_RLD = 0;
	localparam int C2_COUNT_SEL = 1;
	localparam int C2_RUN = 2;
	localparam int C2_EXT_EN = 3;
	localparam int C2_TX_BAUD = 4;
	localparam int C2_RX_BAUD = 5;
	localparam int C2_EXT_FLAG = 6;
	localparam int C2_OVF_FLAG = 7;
	// Fields of the channel 2 mode register and the core configuration register.
	localparam int M2_CLKOUT_EN = 1;
	localparam int CFG_CLK_DOUBLE = 0;
	// Channel 0/1 operating modes.
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	// Machine cycle lengths in oscillator clocks.
	localparam logic [3:0] MC_CLOCKS_STD = 4'hC;
	localparam logic [3:0] MC_CLOCKS_DBL = 4'h6;
	localparam logic [4:0] PRESCALE_FULL = 5'h1F;
	localparam logic [7:0] BYTE_FULL = 8'hFF;
	localparam logic [15:0] WORD_FULL = 16'hFFFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// File: hw/fall_detect.sv
// Falling-edge detector for a group of synchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none
module fall_detect #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Pins and detected edges.
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] prev_reg;

	initial
	begin
		if (WIDTH < 1)
			$error("fall_detect needs at least one pin");
	end

	// Previous level resets high, so a pin held low at reset gives one edge in the first cycle after reset.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			prev_reg <= '1;
		else
			prev_reg <= pin;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_edge
			assign fall[i] = prev_reg[i] & ~pin[i];
		end
	endgenerate
endmodule
`default_nettype wire

// File: testbench/pin_model.sv
// Behavioural model of the gate, count and trigger pins around the timer block.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
	// Clock.
	input wire logic clk,
	// Pins: gate 0, gate 1, count 0, count 1, trigger, channel 2 count.
	output logic [5:0] pins
);
	initial pins = 6'h3F;
	// Pins idle high, so only this pulse or the level task driving a pin low makes a falling edge.
	task automatic fall(input int k);
		@(posedge clk);
		pins[k] <= 1'b0;
		repeat (2) @(posedge clk);
		pins[k] <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// A gate pin holds its level until told otherwise.
	task automatic level(input int k, input logic v);
		@(posedge clk);
		pins[k] <= v;
	endtask
endmodule
`default_nettype wire

// File: testbench/triple_timer_properties.sv
// Port-level assertions for the timer block.
`timescale 1ns/1ns
`default_nettype none
module triple_timer_properties #(
	parameter int ADDR_WIDTH = 4
) (
	// Clock, reset and register port.
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_WIDTH-1:0] addr,
	input wire logic [timer_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [timer_pkg::DATA_W-1:0] rdata,
	// Pins and ticks.
	input wire logic ext_irq1_pin,
	input wire logic p1_0_out,
	input wire logic p1_0_oe,
	input wire logic timer1_ovf_tick,
	input wire logic rx_baud_tick,
	input wire logic tx_baud_tick
);
	import timer_pkg::*;
	// Shadows of the bits that only software writes.
	logic [7:0] mode_s;
	logic [7:0] c2_s;
	logic run1_s;
	logic clko_s;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			mode_s <= RESET_BYTE;
			c2_s <= RESET_BYTE;
			run1_s <= 1'b0;
			clko_s <= 1'b0;
		end
		else if (wr)
		begin
			if (addr == ADDR_MODE01)
				mode_s <= wdata;
			if (addr == ADDR_T2_CTRL)
				c2_s <= wdata;
			if (addr == ADDR_CTRL01)
				run1_s <= wdata[C01_RUN1];
			if (addr == ADDR_T2_MODE)
				clko_s <= wdata[M2_CLKOUT_EN];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence t1_idle;
		mode_s[1:0] != MODE_SPLIT && (mode_s[5:4] == MODE_SPLIT || !run1_s || (mode_s[7] && !ext_irq1_pin));
	endsequence
	AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_UNMAPPED: assert property (rd && addr >= 4'hD |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_MODE_READ: assert property (rd && addr == ADDR_MODE01 |=> rdata == $past(mode_s))
		else $error("mode byte read back wrong");
	AST_CTRL_READ: assert property (rd && addr == ADDR_CTRL01 |=> rdata[7:4] == 4'h0 && rdata[1] == $past(run1_s))
		else $error("control read back wrong");
	AST_PIN_ENABLE: assert property (p1_0_oe == (clko_s && !c2_s[C2_COUNT_SEL]))
		else $error("clock pin enable wrong");
	AST_OUT_QUIET: assert property ((!clko_s) [*2] |-> !p1_0_out)
		else $error("clock pin active while disabled");
	AST_RX_OFF: assert property (!c2_s[C2_RX_BAUD] |-> !rx_baud_tick)
		else $error("receive tick without receive baud");
	AST_TX_OFF: assert property (!c2_s[C2_TX_BAUD] |-> !tx_baud_tick)
		else $error("transmit tick without transmit baud");
	AST_BAUD_PAIR: assert property (c2_s[C2_RX_BAUD] && c2_s[C2_TX_BAUD] |-> rx_baud_tick == tx_baud_tick)
		else $error("receive and transmit ticks differ");
	AST_T1_HELD: assert property (t1_idle [*3] |-> !timer1_ovf_tick)
		else $error("channel 1 overflow while stopped");
	AST_CLK_TOGGLE: assert property (clko_s && !c2_s[C2_COUNT_SEL] && tx_baud_tick |=> p1_0_out != $past(p1_0_out))
		else $error("clock pin did not toggle on overflow");
endmodule
bind triple_timer triple_timer_properties #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
	.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.ext_irq1_pin(ext_irq1_pin), .p1_0_out(p1_0_out), .p1_0_oe(p1_0_oe), .timer1_ovf_tick(timer1_ovf_tick),
	.rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick)
);
`default_nettype wire

// File: testbench/triple_timer_bench.sv
// Register-level tests of the timer block with its pin model.
`timescale 1ns/1ns
`default_nettype none
module triple_timer_bench;
	import timer_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [5:0] pins;
	logic p1_0_out, p1_0_oe, t1_tick, rx_tick, tx_tick;
	logic last_out = 1'b0;
	int fails = 0;
	int n_compared = 0;
	int n_rx = 0;
	int n_tx = 0;
	int n_edge = 0;
	int n_t1 = 0;
	always #50 clk = ~clk;
	pin_model pin_u (.clk(clk), .pins(pins));
	triple_timer dut_u (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]), .t0_count_pin(pins[2]), .t1_count_pin(pins[3]),
		.timer2_trigger_pin(pins[4]), .p1_0_in(pins[5]), .p1_0_out(p1_0_out), .p1_0_oe(p1_0_oe),
		.timer1_ovf_tick(t1_tick), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick)
	);
	always @(negedge clk)
	begin
		if (rx_tick === 1'b1)
			n_rx++;
		if (tx_tick === 1'b1)
			n_tx++;
		if (t1_tick === 1'b1)
			n_t1++;
		if (p1_0_out !== last_out)
			n_edge++;
		last_out = p1_0_out;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	// Runs channel 2 with a reload word of FFFE and counts ticks and pin edges over 80 cycles.
	task automatic measure(input logic [7:0] c, input int exp);
		wreg(ADDR_T2_CTRL, c);
		repeat (10) @(posedge clk);
		n_rx = 0;
		n_tx = 0;
		n_edge = 0;
		repeat (80) @(posedge clk);
		check(8'(n_rx), c[C2_RX_BAUD] ? 8'(exp) : 8'h00);
		check(8'(n_tx), c[C2_TX_BAUD] ? 8'(exp) : 8'h00);
		check(8'(n_edge), 8'(exp));
		check({7'h00, p1_0_oe}, 8'h01);
	endtask
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#(100 * 20000);
		fails++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 16; a++)
			rchk(4'(a), 8'h00);
		for (int a = 2; a < 12; a++)
			if (a != 6 && a != 7)
				wreg(4'(a), 8'(a * 17));
		for (int a = 2; a < 12; a++)
			if (a != 6 && a != 7)
				rchk(4'(a), 8'(a * 17));
		$display("test reset and bytes done");
		wreg(ADDR_MODE01, 8'h31);
		wreg(ADDR_T0_LOW, 8'hF6);
		wreg(ADDR_T0_HIGH, 8'hFF);
		wreg(ADDR_CTRL01, 8'h03);
		// Run edge to stop edge is exactly 120 clocks, ten machine cycles.
		repeat (118) @(posedge clk);
		wreg(ADDR_CTRL01, 8'h00);
		rchk(ADDR_T0_LOW, 8'h00);
		rchk(ADDR_T0_HIGH, 8'h00);
		rchk(ADDR_CTRL01, 8'h04);
		rchk(ADDR_T1_LOW, 8'h44);
		rchk(ADDR_MODE01, 8'h31);
		$display("test timer function done");
		wreg(ADDR_MODE01, 8'h0D);
		pin_u.level(0, 1'b0);
		wreg(ADDR_CTRL01, 8'h01);
		repeat (2) pin_u.fall(2);
		rchk(ADDR_T0_LOW, 8'h00);
		pin_u.level(0, 1'b1);
		repeat (3) pin_u.fall(2);
		rchk(ADDR_T0_LOW, 8'h03);
		wreg(ADDR_MODE01, 8'h06);
		wreg(ADDR_T0_LOW, 8'hFE);
		wreg(ADDR_T0_HIGH, 8'hF0);
		repeat (3) pin_u.fall(2);
		rchk(ADDR_T0_LOW, 8'hF1);
		wreg(ADDR_CTRL01, 8'h00);
		$display("test counter and gate done");
		// Channel 1 counts gated falling edges in 8-bit reload mode; the high byte still holds 55.
		wreg(ADDR_MODE01, 8'hE0);
		wreg(ADDR_T1_LOW, 8'hFE);
		pin_u.level(1, 1'b0);
		wreg(ADDR_CTRL01, 8'h02);
		repeat (2) pin_u.fall(3);
		rchk(ADDR_T1_LOW, 8'hFE);
		pin_u.level(1, 1'b1);
		n_t1 = 0;
		repeat (3) pin_u.fall(3);
		rchk(ADDR_T1_LOW, 8'h56);
		rchk(ADDR_CTRL01, 8'h0A);
		check(8'(n_t1), 8'h01);
		wreg(ADDR_CTRL01, 8'h00);
		// Split channel 0: the high half runs on the channel 1 run bit and owns its flag.
		wreg(ADDR_MODE01, 8'h03);
		wreg(ADDR_T0_HIGH, 8'hFE);
		wreg(ADDR_CTRL01, 8'h02);
		repeat (30) @(posedge clk);
		rchk(ADDR_CTRL01, 8'h0A);
		rchk(ADDR_T0_LOW, 8'hF1);
		wreg(ADDR_CTRL01, 8'h00);
		$display("test channel 1 and split done");
		wreg(ADDR_T2_LOW, 8'h10);
		wreg(ADDR_T2_HIGH, 8'h00);
		wreg(ADDR_T2_RLD_LOW, 8'h00);
		wreg(ADDR_T2_RLD_HIGH, 8'h00);
		wreg(ADDR_T2_CTRL, 8'h07);
		repeat (2) pin_u.fall(5);
		pin_u.fall(4);
		rchk(ADDR_T2_RLD_LOW, 8'h00);
		rchk(ADDR_T2_LOW, 8'h12);
		wreg(ADDR_T2_CTRL, 8'h0F);
		pin_u.fall(4);
		rchk(ADDR_T2_RLD_LOW, 8'h12);
		rchk(ADDR_T2_CTRL, 8'h4F);
		wreg(ADDR_T2_CTRL, 8'h06);
		wreg(ADDR_T2_LOW, 8'hFF);
		wreg(ADDR_T2_HIGH, 8'hFF);
		wreg(ADDR_T2_RLD_LOW, 8'h34);
		wreg(ADDR_T2_RLD_HIGH, 8'h12);
		pin_u.fall(5);
		rchk(ADDR_T2_HIGH, 8'h12);
		rchk(ADDR_T2_CTRL, 8'h86);
		$display("test capture and reload done");
		wreg(ADDR_T2_CTRL, 8'h00);
		wreg(ADDR_T2_RLD_LOW, 8'hFE);
		wreg(ADDR_T2_RLD_HIGH, 8'hFF);
		wreg(ADDR_T2_LOW, 8'hFE);
		wreg(ADDR_T2_HIGH, 8'hFF);
		wreg(ADDR_T2_MODE, 8'h02);
		measure(8'h34, 20);
		measure(8'h24, 20);
		measure(8'h14, 20);
		wreg(ADDR_CORE_CFG, 8'h01);
		measure(8'h34, 40);
		rchk(ADDR_T2_CTRL, 8'h34);
		wreg(ADDR_T2_MODE, 8'h00);
		wreg(ADDR_T2_CTRL, 8'h00);
		repeat (3) @(posedge clk);
		check({6'h00, p1_0_oe, p1_0_out}, 8'h00);
		$display("test clock output done");
		stop_test();
	end
endmodule
`default_nettype wire
